// >>> hdl/adc_intc_pkg.sv
// constants, register map and types of the scan-end interrupt gate
package adc_intc_pkg;

    // ************************************************
    // register map (byte address = index * 4)
    // ************************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] ENR_FIRST = 8'h02;
    localparam logic [7:0] ENR_LAST = 8'h1f;
    localparam int ENR_NUM = 30;
    localparam logic [7:0] ENR_SCAN_INDEX = 8'h0c;
    localparam logic [1:0][7:0] SRC_VECTOR = {8'h67, 8'h66};
    localparam logic [1:0][2:0] SRC_IEN_BIT = {3'h7, 3'h6};
    localparam logic [ADDR_W-1:0] PRIO_SCAN_ADDR = 12'h400;
    localparam logic [ADDR_W-1:0] PRIO_GROUP_B_ADDR = 12'h404;
    localparam logic [ADDR_W-1:0] NMI_EN_ADDR = 12'h500;
    localparam logic [ADDR_W-1:0] NMI_FLAG_ADDR = 12'h504;
    localparam logic [ADDR_W-1:0] STW_ADDR = 12'h600;
    localparam logic [ADDR_W-1:0] PERIPH_CTRL_ADDR = 12'h700;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h710;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h714;

    // ************************************************
    // fields and reset values
    // ************************************************
    localparam int STW_MASK_BIT = 0;
    localparam int STW_IPL_LSB = 4;
    localparam logic STW_MASK_RESET = 1'h0;
    localparam logic [3:0] STW_IPL_RESET = 4'h0;
    localparam int ST_SCAN = 0;
    localparam int ST_GROUP_B = 1;
    localparam int ST_NMI = 2;
    localparam int ST_ACCEPT = 3;
    localparam int ST_W = 4;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // ************************************************
    // types
    // ************************************************
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [3:0] level;
    } cpu_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [ENR_NUM-1:0][7:0] enr;
        logic [1:0][3:0] prio;
        logic nmi_en;
        logic mask_flag;
        logic [3:0] ipl;
        logic [1:0] periph_en;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] irq_mask;
        logic irq;
        cpu_req_t req;
        logic nmi_req;
    } intc_state_t;

endpackage : adc_intc_pkg

// >>> hdl/pin_sync.sv
// three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module pin_sync
    import adc_intc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    input wire logic pin, // asynchronous input
    output logic rise // one-cycle pulse on accepted rise
);
    typedef struct packed {
        logic [2:0] sr;
        logic level;
        logic rise;
    } sync_state_t;

    sync_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.sr = {st_q.sr[1:0], pin};
        st_d.rise = 1'b0;
        // stage 0 feeds stage 1 only
        if (st_q.sr[1] == st_q.sr[2]) begin
            st_d.level = st_q.sr[2];
            st_d.rise = st_q.sr[2] & ~st_q.level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.rise;
endmodule : pin_sync

// >>> hdl/request_flag.sv
// one request flag of the controller, set over clear
`timescale 1ns/1ps
module request_flag
    import adc_intc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    input wire logic event_pulse, // source event
    input wire logic source_en, // enable in the source
    input wire logic clear, // software or acceptance clear
    output logic set_pulse, // event passed the source gate
    output logic flag // request flag
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t st_q, st_d;

    assign set_pulse = event_pulse & source_en;

    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.flag = 1'b0;
        end
        if (set_pulse) begin
            st_d.flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;
endmodule : request_flag

// >>> hdl/adc_intc.sv
// scan-end interrupt gate: enables, flags, priorities, acceptance
`timescale 1ns/1ps
module adc_intc
    import adc_intc_pkg::*;
(
    input wire logic clk, // system clock, 25 MHz
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable, freezes all state
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic scan_end_interrupt, // scan end event pulse
    input wire logic group_b_scan_end_interrupt, // group b event pulse
    input wire logic nmi_pin, // non-maskable pin, asynchronous
    input wire logic cpu_irq_ack, // processor takes offered request
    output cpu_req_t cpu_req, // offered maskable request
    output logic cpu_nmi_req, // offered non-maskable request
    output logic irq // summary interrupt
);
    intc_state_t st_q, st_d;

    logic [1:0] src_event;
    logic [1:0] src_set;
    logic [1:0] src_flag;
    logic [1:0] src_clr;
    logic [1:0] ack_clr;
    logic nmi_rise;
    logic nmi_set;
    logic nmi_flag;
    logic nmi_clr;
    logic do_write;
    logic do_read;
    logic status_read;

    // ************************************************
    // request flags
    // ************************************************
    assign src_event = {group_b_scan_end_interrupt, scan_end_interrupt};

    for (genvar i = 0; i < 2; i++) begin : g_src
        request_flag u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .event_pulse(src_event[i]),
            .source_en(st_q.periph_en[i]),
            .clear(src_clr[i] | ack_clr[i]),
            .set_pulse(src_set[i]),
            .flag(src_flag[i])
        );
    end

    pin_sync u_nmi_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(nmi_pin),
        .rise(nmi_rise)
    );

    request_flag u_nmi_flag (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .event_pulse(nmi_rise),
        .source_en(1'b1),
        .clear(nmi_clr),
        .set_pulse(nmi_set),
        .flag(nmi_flag)
    );

    // ************************************************
    // bus decode
    // ************************************************
    assign do_write = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
    assign do_read = s_axi_arvalid & st_q.arready;
    assign status_read = do_read & (s_axi_araddr == STATUS_ADDR);

    function automatic logic is_enr(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a[11:2] >= {2'h0, ENR_FIRST})
            && (a[11:2] <= {2'h0, ENR_LAST});
    endfunction : is_enr

    function automatic logic [4:0] enr_slot(input logic [ADDR_W-1:0] a);
        return 5'(a[6:2] - ENR_FIRST[4:0]);
    endfunction : enr_slot

    function automatic logic is_flag(input logic [ADDR_W-1:0] a, input int i);
        return a == {2'h0, SRC_VECTOR[i], 2'h0};
    endfunction : is_flag

    always_comb begin
        src_clr = '0;
        nmi_clr = 1'b0;
        for (int i = 0; i < 2; i++) begin
            src_clr[i] = do_write & st_q.wstrb0 & is_flag(st_q.waddr, i) & ~st_q.wdata[0];
        end
        if (do_write && st_q.wstrb0 && st_q.waddr == NMI_FLAG_ADDR) begin
            nmi_clr = ~st_q.wdata[0];
        end
    end

    always_comb begin
        ack_clr = '0;
        for (int i = 0; i < 2; i++) begin
            ack_clr[i] = cpu_irq_ack & st_q.req.valid & (st_q.req.vector == SRC_VECTOR[i]);
        end
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [31:0] rd;
        logic rd_ok;
        logic [3:0] best;
        logic [ST_W-1:0] ev;
        logic cand;
        rd = '0;
        rd_ok = 1'b1;
        best = '0;
        ev = '0;
        cand = 1'b0;
        st_d = st_q;

        // write channel
        st_d.awready = ~st_d.aw_held;
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.waddr = s_axi_awaddr;
            st_d.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (do_write) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = AXI_OKAY;
            if (is_enr(st_q.waddr)) begin
                if (st_q.wstrb0) begin
                    st_d.enr[enr_slot(st_q.waddr)] = st_q.wdata[7:0];
                end
            end else if (st_q.wstrb0) begin
                case (st_q.waddr)
                    PRIO_SCAN_ADDR: st_d.prio[0] = st_q.wdata[3:0];
                    PRIO_GROUP_B_ADDR: st_d.prio[1] = st_q.wdata[3:0];
                    NMI_EN_ADDR: st_d.nmi_en = st_q.wdata[0];
                    STW_ADDR: begin
                        st_d.mask_flag = st_q.wdata[STW_MASK_BIT];
                        st_d.ipl = st_q.wdata[STW_IPL_LSB +: 4];
                    end
                    PERIPH_CTRL_ADDR: st_d.periph_en = st_q.wdata[1:0];
                    MASK_ADDR: st_d.irq_mask = st_q.wdata[ST_W-1:0];
                    STATUS_ADDR: st_d.irq_mask = st_q.irq_mask;
                    default: begin
                        if (!is_flag(st_q.waddr, 0) && !is_flag(st_q.waddr, 1)
                            && st_q.waddr != NMI_FLAG_ADDR) begin
                            st_d.bresp = AXI_SLVERR;
                        end
                    end
                endcase
            end
        end
        st_d.wready = ~st_d.w_held;

        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (is_enr(s_axi_araddr)) begin
            rd[7:0] = st_q.enr[enr_slot(s_axi_araddr)];
        end else if (is_flag(s_axi_araddr, 0)) begin
            rd[0] = src_flag[0];
        end else if (is_flag(s_axi_araddr, 1)) begin
            rd[0] = src_flag[1];
        end else begin
            case (s_axi_araddr)
                PRIO_SCAN_ADDR: rd[3:0] = st_q.prio[0];
                PRIO_GROUP_B_ADDR: rd[3:0] = st_q.prio[1];
                NMI_EN_ADDR: rd[0] = st_q.nmi_en;
                NMI_FLAG_ADDR: rd[0] = nmi_flag;
                STW_ADDR: begin
                    rd[STW_MASK_BIT] = st_q.mask_flag;
                    rd[STW_IPL_LSB +: 4] = st_q.ipl;
                end
                PERIPH_CTRL_ADDR: rd[1:0] = st_q.periph_en;
                STATUS_ADDR: rd[ST_W-1:0] = st_q.status;
                MASK_ADDR: rd[ST_W-1:0] = st_q.irq_mask;
                default: rd_ok = 1'b0;
            endcase
        end
        if (do_read) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd;
            st_d.rresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
        end
        st_d.arready = ~st_d.rvalid;

        // arbitration: highest level wins, lower vector on a tie
        st_d.req = '0;
        for (int i = 0; i < 2; i++) begin
            cand = src_flag[i] & ~ack_clr[i]
                & st_q.enr[ENR_SCAN_INDEX - ENR_FIRST][SRC_IEN_BIT[i]]
                & (st_q.prio[i] != 4'h0)
                & st_q.mask_flag
                & (st_q.prio[i] > st_q.ipl);
            if (cand && st_q.prio[i] > best) begin
                best = st_q.prio[i];
                st_d.req.valid = 1'b1;
                st_d.req.vector = SRC_VECTOR[i];
                st_d.req.level = st_q.prio[i];
            end
        end
        st_d.nmi_req = nmi_flag & ~nmi_clr & st_q.nmi_en;

        // sticky status, set wins over read-clear
        ev[ST_SCAN] = src_set[0];
        ev[ST_GROUP_B] = src_set[1];
        ev[ST_NMI] = nmi_set;
        ev[ST_ACCEPT] = cpu_irq_ack & st_q.req.valid;
        if (status_read) begin
            st_d.status = '0;
        end
        st_d.status = st_d.status | ev;
        st_d.irq = |(st_d.status & st_d.irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = st_q.rdata;
    assign cpu_req = st_q.req;
    assign cpu_nmi_req = st_q.nmi_req;
    assign irq = st_q.irq;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_prio_write;
        ce && do_write && st_q.wstrb0 && st_q.waddr == PRIO_SCAN_ADDR;
    endsequence

    sequence s_scan_event;
        ce && scan_end_interrupt && st_q.periph_en[0];
    endsequence

    a_mask_gates_req: assert property (
        ce && st_d.req.valid |=> st_q.req.valid && $past(st_q.mask_flag))
        else $error("request offered while masked");

    a_level_above_ipl: assert property (
        ce && st_d.req.valid |=> st_q.req.level > $past(st_q.ipl))
        else $error("request level not above threshold");

    a_enable_gates_req: assert property (
        ce && st_d.req.valid && st_d.req.vector == SRC_VECTOR[1]
        |-> st_q.enr[ENR_SCAN_INDEX - ENR_FIRST][SRC_IEN_BIT[1]] && st_q.prio[1] != 4'h0)
        else $error("disabled source offered");

    a_periph_blocks: assert property (
        ce && !src_flag[0] && !(scan_end_interrupt && st_q.periph_en[0]) |=> !src_flag[0])
        else $error("flag set without converter enable");

    a_event_sets_flag: assert property (s_scan_event |=> src_flag[0] && st_q.status[ST_SCAN])
        else $error("enabled event lost");

    a_flag_holds: assert property (
        ce && src_flag[1] && !src_clr[1] && !ack_clr[1] |=> src_flag[1])
        else $error("flag dropped without clear");

    a_prio_written: assert property (s_prio_write |=> st_q.prio[0] == $past(st_q.wdata[3:0]))
        else $error("priority write not applied");

    a_reset_masked: assert property (disable iff (1'b0)
        $rose(rst_n) |-> !st_q.mask_flag && st_q.ipl == 4'h0 && !cpu_req.valid)
        else $error("mask or threshold wrong after reset");

    a_nmi_gate: assert property (ce && st_d.nmi_req |=> cpu_nmi_req && $past(st_q.nmi_en))
        else $error("non-maskable request without enable");

endmodule : adc_intc

// >>> test/cpu_core_model.sv
// processor core model that accepts offered maskable requests
`timescale 1ns/1ps
module cpu_core_model
    import adc_intc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic accept_en, // core may accept
    input wire logic [1:0] delay, // idle cycles before accepting
    input wire cpu_req_t req, // offered request
    output logic ack, // one-cycle acceptance pulse
    output logic [7:0] last_vector, // vector last accepted
    output int taken // acceptances so far
);
    logic [1:0] wait_q;

    // ************************************************
    // acceptance, one pulse per offered request
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            wait_q <= 2'h0;
            last_vector <= 8'h00;
            taken <= 0;
        end else if (ack || !req.valid || !accept_en) begin
            ack <= 1'b0;
            wait_q <= 2'h0;
        end else if (wait_q == delay) begin
            ack <= 1'b1;
            last_vector <= req.vector;
            taken <= taken + 1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule : cpu_core_model

// >>> test/tb.sv
// self-checking bench of the scan-end interrupt gate
`timescale 1ns/1ps
module tb;
    import adc_intc_pkg::*;
    localparam logic [ADDR_W-1:0] A_EN = {2'h0, ENR_SCAN_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] A_F0 = {2'h0, SRC_VECTOR[0], 2'h0};
    localparam logic [ADDR_W-1:0] A_F1 = {2'h0, SRC_VECTOR[1], 2'h0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic scan_ev = 1'b0;
    logic grp_ev = 1'b0;
    logic nmi_pin = 1'b0;
    logic accept_en = 1'b0;
    logic [1:0] delay = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, ack, nmi_req, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] last_vector;
    cpu_req_t cpu_req;
    int taken;
    int want;
    int checks = 0;
    int mismatches = 0;

    always #20 clk = ~clk;

    adc_intc adc_intc_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .scan_end_interrupt(scan_ev), .group_b_scan_end_interrupt(grp_ev), .nmi_pin(nmi_pin),
        .cpu_irq_ack(ack), .cpu_req(cpu_req), .cpu_nmi_req(nmi_req), .irq(irq));

    cpu_core_model cpu_core_model_i (.clk(clk), .rst_n(rst_n), .accept_en(accept_en),
        .delay(delay), .req(cpu_req), .ack(ack), .last_vector(last_vector), .taken(taken));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_up(input int n);
        if (n >= 40) begin
            mismatches++;
            test_done();
        end
    endtask : give_up

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        give_up(n);
        check("write response", {30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        give_up(n);
        check(what, rdata, ed);
        check("read response", {30'h0, rresp}, {30'h0, er});
    endtask : rc

    function automatic logic sig(input int which);
        case (which)
            0: return cpu_req.valid;
            1: return irq;
            2: return nmi_req;
            default: return logic'(taken == want);
        endcase
    endfunction : sig

    task automatic wait_on(input int which, input logic exp, input string what);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (sig(which) === exp) break;
        end
        give_up(n);
        check(what, sig(which), exp);
    endtask : wait_on

    task automatic pulse(input logic s, input logic g);
        scan_ev <= s;
        grp_ev <= g;
        @(posedge clk);
        scan_ev <= 1'b0;
        grp_ev <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset();
        check("req after reset", cpu_req.valid, 1'b0);
        rc("status word", STW_ADDR, 32'h0, AXI_OKAY);
        rc("scan enables", A_EN, 32'h0, AXI_OKAY);
        wr(12'h008, 32'h5a, AXI_OKAY);
        wr(12'h07c, 32'ha5, AXI_OKAY);
        rc("enable 02h", 12'h008, 32'h5a, AXI_OKAY);
        rc("enable 1fh", 12'h07c, 32'ha5, AXI_OKAY);
        wr(12'h080, 32'h1, AXI_SLVERR);
        rc("beyond 1fh", 12'h080, 32'h0, AXI_SLVERR);
    endtask : t_reset

    task automatic t_mask();
        wr(PERIPH_CTRL_ADDR, 32'h3, AXI_OKAY);
        wr(A_EN, 32'hc0, AXI_OKAY);
        wr(PRIO_SCAN_ADDR, 32'h5, AXI_OKAY);
        rc("scan priority", PRIO_SCAN_ADDR, 32'h5, AXI_OKAY);
        pulse(1'b1, 1'b0);
        check("masked req", cpu_req.valid, 1'b0);
        rc("scan flag", A_F0, 32'h1, AXI_OKAY);
        rc("group b flag", A_F1, 32'h0, AXI_OKAY);
        wr(STW_ADDR, 32'h1, AXI_OKAY);
        wait_on(0, 1'b1, "unmasked req");
        check("req vector", cpu_req.vector, SRC_VECTOR[0]);
        check("req level", cpu_req.level, 4'h5);
        accept_en <= 1'b1;
        wait_on(0, 1'b0, "req after accept");
        accept_en <= 1'b0;
        rc("flag after accept", A_F0, 32'h0, AXI_OKAY);
    endtask : t_mask

    task automatic t_gate();
        wr(PERIPH_CTRL_ADDR, 32'h0, AXI_OKAY);
        pulse(1'b1, 1'b0);
        rc("gated flag", A_F0, 32'h0, AXI_OKAY);
        wr(PERIPH_CTRL_ADDR, 32'h3, AXI_OKAY);
        wr(A_EN, 32'h80, AXI_OKAY);
        pulse(1'b1, 1'b0);
        check("no ctrl enable", cpu_req.valid, 1'b0);
        wr(A_EN, 32'hc0, AXI_OKAY);
        wait_on(0, 1'b1, "held flag req");
        wr(PRIO_SCAN_ADDR, 32'h0, AXI_OKAY);
        wait_on(0, 1'b0, "zero priority");
        wr(PRIO_SCAN_ADDR, 32'h5, AXI_OKAY);
        wr(STW_ADDR, 32'h51, AXI_OKAY);
        repeat (4) @(posedge clk);
        check("equal threshold", cpu_req.valid, 1'b0);
        wr(STW_ADDR, 32'h41, AXI_OKAY);
        wait_on(0, 1'b1, "lower threshold");
        wr(A_F0, 32'h0, AXI_OKAY);
        wait_on(0, 1'b0, "cleared flag");
    endtask : t_gate

    task automatic t_order();
        wr(STW_ADDR, 32'h1, AXI_OKAY);
        wr(PRIO_SCAN_ADDR, 32'h3, AXI_OKAY);
        wr(PRIO_GROUP_B_ADDR, 32'h7, AXI_OKAY);
        delay <= 2'h2;
        accept_en <= 1'b1;
        want = taken + 1;
        pulse(1'b1, 1'b1);
        wait_on(3, 1'b1, "first accept");
        check("first vector", last_vector, SRC_VECTOR[1]);
        want = taken + 1;
        wait_on(3, 1'b1, "second accept");
        check("second vector", last_vector, SRC_VECTOR[0]);
        rc("group b flag", A_F1, 32'h0, AXI_OKAY);
        accept_en <= 1'b0;
    endtask : t_order

    task automatic t_irq();
        wr(STW_ADDR, 32'h0, AXI_OKAY);
        rc("status sticky", STATUS_ADDR, 32'hb, AXI_OKAY);
        wr(MASK_ADDR, 32'h1, AXI_OKAY);
        pulse(1'b0, 1'b1);
        check("masked irq", irq, 1'b0);
        rc("group b status", STATUS_ADDR, 32'h2, AXI_OKAY);
        rc("status cleared", STATUS_ADDR, 32'h0, AXI_OKAY);
        pulse(1'b1, 1'b0);
        wait_on(1, 1'b1, "irq raised");
        rc("scan status", STATUS_ADDR, 32'h1, AXI_OKAY);
        wait_on(1, 1'b0, "irq cleared");
    endtask : t_irq

    task automatic t_nmi();
        nmi_pin <= 1'b1;
        repeat (10) @(posedge clk);
        check("nmi disabled", nmi_req, 1'b0);
        rc("nmi flag", NMI_FLAG_ADDR, 32'h1, AXI_OKAY);
        wr(NMI_EN_ADDR, 32'h1, AXI_OKAY);
        wait_on(2, 1'b1, "nmi enabled");
        check("maskable quiet", cpu_req.valid, 1'b0);
        wr(NMI_FLAG_ADDR, 32'h0, AXI_OKAY);
        wait_on(2, 1'b0, "nmi cleared");
        nmi_pin <= 1'b0;
    endtask : t_nmi

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_mask();
        t_gate();
        t_order();
        t_irq();
        t_nmi();
        test_done();
    end
endmodule : tb
